// ---- logic/sfrsic_bus_if.sv ----
// Two-wire bus between sensor end and master end
`timescale 1ns/10ps
interface sfrsic_bus_if;
   logic sclOut;
   logic sclOe;
   logic sdaMasterOut;
   logic sdaMasterOe;
   logic sdaSlaveOut;
   logic sdaSlaveOe;
   logic scl;
   logic sda;

   // Open drain with pull-up: any enabled driver pulls low
   assign scl = ~(sclOe & ~sclOut);
   assign sda = ~((sdaMasterOe & ~sdaMasterOut) | (sdaSlaveOe & ~sdaSlaveOut));

   modport sensor (input scl, input sda, output sdaSlaveOut, output sdaSlaveOe);
   modport master (input scl, input sda, output sclOut, output sclOe,
                   output sdaMasterOut, output sdaMasterOe);
endinterface

// ---- logic/sfrsic_master.sv ----
// Master end: issues write/read transfers on the two-wire bus
`timescale 1ns/10ps
module sfrsic_master #(
   parameter int HALF_CYCLES = sfrsic_pkg::SCL_HALF_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        clkEn,
   sfrsic_bus_if.master     bus,
   input  wire logic        reqValid,
   output logic             reqReady,
   input  wire logic [6:0]  reqAddr,
   input  wire logic        reqRead,
   input  wire logic [1:0]  reqWrLen,
   input  wire logic [15:0] reqWrData,
   input  wire logic [4:0]  reqRdLen,
   output logic             addrAcked,
   output logic             rdValid,
   output logic [7:0]       rdData,
   output logic             done,
   output logic             crcOk
);
   initial begin
      if (HALF_CYCLES < 2 || HALF_CYCLES > 255) $error("sfrsic_master: bad HALF_CYCLES");
   end

   typedef enum {MS_IDLE, MS_START, MS_BIT, MS_ACK, MS_STOP} sfrsic_mstate_type;
   sfrsic_mstate_type st, next_st;
   logic [7:0]  div, next_div;
   logic        phase, next_phase;
   logic [7:0]  sh, next_sh;
   logic [2:0]  bitN, next_bitN;
   logic [4:0]  left, next_left;
   logic [1:0]  wrLeft, next_wrLeft;
   logic [15:0] wrBuf, next_wrBuf;
   logic        inAddr, next_inAddr;
   logic        rd, next_rd;
   logic        sclLow, next_sclLow;
   logic        sdaLow, next_sdaLow;
   logic        acked, next_acked;
   logic [15:0] word, next_word;
   logic [1:0]  pos, next_pos;
   logic        ok, next_ok;
   logic        rv, next_rv;
   logic [7:0]  rdq, next_rdq;
   logic        dn, next_dn;
   logic [1:0]  sdaSync;

   // Bus data passes two flops before use
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) sdaSync <= 2'h3;
      else if (clkEn) sdaSync <= {sdaSync[0], bus.sda};
   end

   logic tick;
   assign tick = (div == 8'h00);

   always_comb begin
      next_st = st; next_div = tick ? 8'(HALF_CYCLES - 1) : div - 8'h1;
      next_phase = phase; next_sh = sh; next_bitN = bitN; next_left = left;
      next_wrLeft = wrLeft; next_wrBuf = wrBuf; next_inAddr = inAddr; next_rd = rd;
      next_sclLow = sclLow; next_sdaLow = sdaLow; next_acked = acked; next_word = word;
      next_pos = pos; next_ok = ok; next_rv = 1'b0; next_rdq = rdq; next_dn = 1'b0;
      case (st)
         MS_IDLE: begin
            next_div = 8'(HALF_CYCLES - 1);
            if (reqValid) begin
               next_st = MS_START; next_sdaLow = 1'b1; next_phase = 1'b0;
               next_sh = {reqAddr, reqRead}; next_rd = reqRead; next_inAddr = 1'b1;
               next_wrLeft = reqWrLen; next_wrBuf = reqWrData; next_left = reqRdLen;
               next_acked = 1'b0; next_pos = 2'h0; next_ok = 1'b1;
            end
         end
         MS_START: if (tick) begin
            next_st = MS_BIT; next_sclLow = 1'b1; next_bitN = 3'h0; next_phase = 1'b0;
         end
         MS_BIT: if (tick) begin
            if (!phase) begin
               next_sdaLow = (inAddr || !rd) ? ~sh[7] : 1'b0;
               next_sclLow = 1'b0; next_phase = 1'b1;
            end else begin
               next_sh = {sh[6:0], sdaSync[1]}; next_sclLow = 1'b1; next_phase = 1'b0;
               next_bitN = bitN + 3'h1;
               if (bitN == 3'h7) begin
                  next_st = MS_ACK;
                  next_sdaLow = (!inAddr && rd) ? (left != 5'h1) : 1'b0;
               end
            end
         end
         MS_ACK: if (tick) begin
            if (!phase) begin
               next_sclLow = 1'b0; next_phase = 1'b1;
            end else begin
               next_sclLow = 1'b1; next_phase = 1'b0; next_st = MS_BIT; next_inAddr = 1'b0;
               if (inAddr) next_acked = ~sdaSync[1];
               if (!inAddr && rd) begin
                  next_rv = 1'b1; next_rdq = sh; next_left = left - 5'h1;
                  next_pos = (pos == 2'h2) ? 2'h0 : pos + 2'h1;
                  if (pos == 2'h2) begin
                     // Host check of each word's checksum
                     if (sfrsic_pkg::sfrsic_crc_word(word) != sh) next_ok = 1'b0;
                  end else begin
                     next_word = {word[7:0], sh};
                  end
               end
               if (inAddr && sdaSync[1]) next_st = MS_STOP;
               else if (rd && (left == 5'h1 || (inAddr && left == 5'h0))) next_st = MS_STOP;
               else if (!rd && wrLeft == 2'h0) next_st = MS_STOP;
               else if (!rd) begin
                  next_sh = wrBuf[15:8]; next_wrBuf = {wrBuf[7:0], 8'h00};
                  next_wrLeft = wrLeft - 2'h1;
               end
               if (next_st == MS_STOP) next_sdaLow = 1'b1;
               else next_sdaLow = 1'b0;
            end
         end
         MS_STOP: if (tick) begin
            if (sclLow) next_sclLow = 1'b0;
            else begin
               next_sdaLow = 1'b0; next_st = MS_IDLE; next_dn = 1'b1;
            end
         end
         default: next_st = MS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= MS_IDLE; div <= 8'h00; phase <= 1'b0; sh <= 8'h00; bitN <= 3'h0;
         left <= 5'h00; wrLeft <= 2'h0; wrBuf <= 16'h0000; inAddr <= 1'b0; rd <= 1'b0;
         sclLow <= 1'b0; sdaLow <= 1'b0; acked <= 1'b0; word <= 16'h0000; pos <= 2'h0;
         ok <= 1'b1; rv <= 1'b0; rdq <= 8'h00; dn <= 1'b0;
      end else if (clkEn) begin
         st <= next_st; div <= next_div; phase <= next_phase; sh <= next_sh;
         bitN <= next_bitN; left <= next_left; wrLeft <= next_wrLeft; wrBuf <= next_wrBuf;
         inAddr <= next_inAddr; rd <= next_rd; sclLow <= next_sclLow;
         sdaLow <= next_sdaLow; acked <= next_acked; word <= next_word; pos <= next_pos;
         ok <= next_ok; rv <= next_rv; rdq <= next_rdq; dn <= next_dn;
      end
   end

   assign bus.sclOut       = 1'b0;
   assign bus.sclOe        = sclLow;
   assign bus.sdaMasterOut = 1'b0;
   assign bus.sdaMasterOe  = sdaLow;
   assign reqReady  = (st == MS_IDLE);
   assign addrAcked = acked;
   assign rdValid   = rv;
   assign rdData    = rdq;
   assign done      = dn;
   assign crcOk     = ok;
endmodule

// ---- logic/sfrsic_pkg.sv ----
// Shared constants for the reset, sleep, identifier and checksum command block
package sfrsic_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_HZ        = 10000000;
   localparam int RESET_TIME_US     = 2000;
   localparam int WAKE_TIME_US      = 16000;
   localparam int STOP_TIME_US      = 500;
   localparam int RESET_CYCLES      = RESET_TIME_US * (SYS_CLK_HZ / 1000000);
   localparam int WAKE_CYCLES       = WAKE_TIME_US * (SYS_CLK_HZ / 1000000);
   localparam int STOP_CYCLES       = STOP_TIME_US * (SYS_CLK_HZ / 1000000);
   localparam int SCL_HALF_CYCLES   = 4;
   // ----------------------------------------------------------------
   // Bus addresses and command codes
   // ----------------------------------------------------------------
   localparam logic [6:0]  GENERAL_CALL_ADDR = 7'h00;
   localparam logic [6:0]  DEFAULT_ADDR      = 7'h2e;
   localparam logic [7:0]  CMD_SOFT_RESET    = 8'h06;
   localparam logic [15:0] CMD_ENTER_SLEEP   = 16'h3677;
   localparam logic [15:0] CMD_READ_IDENT    = 16'he102;
   localparam logic [15:0] CMD_STOP_MEASURE  = 16'h3ff9;
   localparam logic [15:0] CMD_START_MEASURE = 16'h3603;
   localparam int          IDENT_BYTES       = 18;
   // ----------------------------------------------------------------
   // Checksum
   // ----------------------------------------------------------------
   localparam logic [7:0]  CRC_POLY          = 8'h31;
   localparam logic [7:0]  CRC_INIT          = 8'hff;
   localparam logic [7:0]  CRC_FINAL_XOR     = 8'h00;

   function automatic logic [7:0] sfrsic_crc_byte(input logic [7:0] crc,
                                                  input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   function automatic logic [7:0] sfrsic_crc_word(input logic [15:0] word);
      return sfrsic_crc_byte(sfrsic_crc_byte(CRC_INIT, word[15:8]), word[7:0]) ^ CRC_FINAL_XOR;
   endfunction
endpackage

// ---- logic/sfrsic_sensor.sv ----
// Sensor end: soft reset, sleep, identifier readout with checksums
// Operation
// - General call plus 0x06 resets separately
// - Reset command is one byte only
// - No acknowledge for 2ms after reset
// - Sleep entered only from idle
// - Asleep ignores general call reset
// - Sleep code 0x3677 accepted when idle
// - Own address with write wakes sensor
// - Waking address byte is not acknowledged
// - Wake takes about 16ms until acknowledge
// - Identifier 0xE102 accepted only when idle
// - Read returns 32+64 bits, 18 bytes
// - Low product byte holds revision
// - Checksum follows every 16-bit word
// - CRC-8 poly 0x31, init 0xff, no reflect
// - Measuring rejects all but reset and stop
// - Stop returns to idle within 0.5ms
`timescale 1ns/10ps
module sfrsic_sensor #(
   parameter logic [6:0]  SLAVE_ADDR    = sfrsic_pkg::DEFAULT_ADDR,
   parameter logic [23:0] PRODUCT_BASE  = 24'h5a5a5a, // Arbitrary value
   parameter logic [7:0]  REVISION      = 8'h10,      // Arbitrary value
   parameter logic [63:0] SERIAL_NUMBER = 64'h0123456789abcdef,
   parameter int          RESET_CYCLES  = sfrsic_pkg::RESET_CYCLES,
   parameter int          WAKE_CYCLES   = sfrsic_pkg::WAKE_CYCLES,
   parameter int          STOP_CYCLES   = sfrsic_pkg::STOP_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic clkEn,
   sfrsic_bus_if.sensor bus,
   output logic      asleep,
   output logic      measuring,
   output logic      resetBusy,
   output logic      waking
);
   initial begin
      if (RESET_CYCLES < 1 || WAKE_CYCLES < 1 || STOP_CYCLES < 1 || RESET_CYCLES > 1000000 ||
          WAKE_CYCLES > 1000000 || STOP_CYCLES > 1000000) $error("sfrsic_sensor: bad cycle counts");
   end
   typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WR_ACK, ST_READ, ST_RD_ACK,
                 ST_IGNORE} sfrsic_bus_state_type;
   typedef enum {MD_IDLE, MD_MEASURE, MD_STOPPING, MD_SLEEP, MD_WAKING, MD_RESET}
      sfrsic_mode_type;
   // ----------------------------------------------------------------
   // Pin synchronisers and edge detect
   // ----------------------------------------------------------------
   logic [1:0] sclSync;
   logic [1:0] sdaSync;
   logic       sclPrev;
   logic       sdaPrev;
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclSync <= 2'h3;
         sdaSync <= 2'h3;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else if (clkEn) begin
         sclSync <= {sclSync[0], bus.scl};
         sdaSync <= {sdaSync[0], bus.sda};
         sclPrev <= sclSync[1];
         sdaPrev <= sdaSync[1];
      end
   end
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   assign sclRise   = sclSync[1] & ~sclPrev;
   assign sclFall   = ~sclSync[1] & sclPrev;
   assign startSeen = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
   assign stopSeen  = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];
   // ----------------------------------------------------------------
   // Bus and mode state
   // ----------------------------------------------------------------
   sfrsic_bus_state_type state, next_state;
   sfrsic_mode_type      mode, next_mode;
   logic [7:0]  shift, next_shift;
   logic [2:0]  bitCnt, next_bitCnt;
   logic [4:0]  byteCnt, next_byteCnt;
   logic        isGcall, next_isGcall;
   logic        identPtr, next_identPtr;
   logic        sdaLow, next_sdaLow;
   logic [15:0] cmd, next_cmd;
   logic [23:0] timer, next_timer;
   logic [95:0] identData;
   assign identData = {PRODUCT_BASE, REVISION, SERIAL_NUMBER};
   // Byte n of the 18-byte readout; every third byte is the word's checksum
   function automatic logic [7:0] identByte(input logic [4:0] idx);
      logic [2:0]  word;
      logic [15:0] w;
      word = 3'(idx / 5'd3);
      w    = identData[95 - 16 * int'(word) -: 16];
      case (idx % 5'd3)
         5'd0:    identByte = w[15:8];
         5'd1:    identByte = w[7:0];
         default: identByte = sfrsic_pkg::sfrsic_crc_word(w);
      endcase
   endfunction
   always_comb begin
      next_state    = state;
      next_mode     = mode;
      next_shift    = shift;
      next_bitCnt   = bitCnt;
      next_byteCnt  = byteCnt;
      next_isGcall  = isGcall;
      next_identPtr = identPtr;
      next_sdaLow   = sdaLow;
      next_cmd      = cmd;
      next_timer    = (timer != 24'h0) ? timer - 24'h1 : 24'h0;
      // Timed mode exits
      case (mode)
         MD_RESET, MD_WAKING, MD_STOPPING: begin
            if (timer == 24'h0) begin
               next_mode = MD_IDLE;
            end
         end
         default: ;
      endcase
      if (stopSeen) begin
         next_state  = ST_IDLE;
         next_sdaLow = 1'b0;
      end else if (startSeen) begin
         next_state   = ST_ADDR;
         next_byteCnt = 5'h0;
         next_sdaLow = 1'b0;
      end else begin
         case (state)
            ST_IDLE, ST_IGNORE: ;
            ST_ADDR: begin
               if (sclRise) begin
                  next_shift   = {shift[6:0], sdaSync[1]};
                  next_byteCnt = byteCnt + 5'h1;
               end
               if (sclFall && byteCnt == 5'h8) begin // The fall after start carries no bit
                  next_state = ST_IGNORE;
                  if (mode == MD_SLEEP) begin
                     // Wake without acknowledge; others stay ignored
                     if (shift == {SLAVE_ADDR, 1'b0}) begin
                        next_mode  = MD_WAKING;
                        next_timer = 24'(WAKE_CYCLES);
                     end
                  end else if (mode != MD_RESET && mode != MD_WAKING) begin
                     if (shift[7:1] == SLAVE_ADDR ||
                         shift == {sfrsic_pkg::GENERAL_CALL_ADDR, 1'b0}) begin
                        next_state    = ST_ADDR_ACK;
                        next_sdaLow   = 1'b1;
                        next_isGcall  = (shift[7:1] == sfrsic_pkg::GENERAL_CALL_ADDR);
                        next_byteCnt  = 5'h0;
                        next_identPtr = shift[0] ? identPtr : 1'b0;
                     end
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (sclFall) begin
                  next_bitCnt = 3'h0;
                  if (shift[0]) begin
                     next_state  = ST_READ;
                     next_shift  = identByte(byteCnt);
                     next_sdaLow = identPtr & ~next_shift[7];
                  end else begin
                     next_state  = ST_WRITE;
                     next_sdaLow = 1'b0;
                  end
               end
            end
            ST_WRITE: begin
               if (sclRise) begin
                  next_shift  = {shift[6:0], sdaSync[1]};
                  next_bitCnt = bitCnt + 3'h1;
               end
               if (sclFall && bitCnt == 3'h0) begin
                  next_state   = ST_WR_ACK;
                  next_sdaLow  = 1'b1;
                  next_cmd     = {cmd[7:0], shift};
                  next_byteCnt = byteCnt + 5'h1;
               end
            end
            ST_WR_ACK: begin
               // Commands act after their ack, so no mode change meets a driven ack
               if (sclFall && isGcall) begin
                  if (byteCnt == 5'h1 && cmd[7:0] == sfrsic_pkg::CMD_SOFT_RESET &&
                      mode != MD_SLEEP) begin
                     next_mode     = MD_RESET;
                     next_timer    = 24'(RESET_CYCLES);
                     next_identPtr = 1'b0;
                  end
               end else if (sclFall && !byteCnt[0]) begin
                  case (cmd)
                     sfrsic_pkg::CMD_ENTER_SLEEP:
                        if (mode == MD_IDLE) next_mode = MD_SLEEP;
                     sfrsic_pkg::CMD_READ_IDENT:
                        if (mode == MD_IDLE) next_identPtr = 1'b1;
                     sfrsic_pkg::CMD_START_MEASURE:
                        if (mode == MD_IDLE) next_mode = MD_MEASURE;
                     sfrsic_pkg::CMD_STOP_MEASURE:
                        if (mode == MD_MEASURE) begin
                           next_mode  = MD_STOPPING;
                           next_timer = 24'(STOP_CYCLES);
                        end
                     default: ;
                  endcase
               end
               if (sclFall) begin
                  next_state  = (next_mode inside {MD_RESET, MD_SLEEP}) ? ST_IGNORE : ST_WRITE;
                  next_sdaLow = 1'b0;
                  next_bitCnt = 3'h0;
               end
            end
            ST_READ: begin
               if (sclFall) begin
                  next_bitCnt = bitCnt + 3'h1;
                  if (bitCnt == 3'h7) begin
                     next_state  = ST_RD_ACK;
                     next_sdaLow = 1'b0;
                  end else begin
                     next_shift  = {shift[6:0], 1'b1};
                     next_sdaLow = identPtr & ~shift[6];
                  end
               end
            end
            ST_RD_ACK: begin
               if (sclRise) begin
                  next_state = sdaSync[1] ? ST_IGNORE : ST_ADDR_ACK; // Nack ends the read
               end
               if (sclRise && !sdaSync[1]) begin
                  // Reuse the ack step to load the next byte of the 18
                  next_byteCnt = (byteCnt == 5'(sfrsic_pkg::IDENT_BYTES - 1)) ? 5'h0
                                                                             : byteCnt + 5'h1;
               end
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state    <= ST_IDLE;
         mode     <= MD_IDLE;
         shift    <= 8'h00;
         bitCnt   <= 3'h0;
         byteCnt  <= 5'h00;
         isGcall  <= 1'b0;
         identPtr <= 1'b0;
         sdaLow   <= 1'b0;
         cmd      <= 16'h0000;
         timer    <= 24'h000000;
      end else if (clkEn) begin
         state    <= next_state;
         mode     <= next_mode;
         shift    <= next_shift;
         bitCnt   <= next_bitCnt;
         byteCnt  <= next_byteCnt;
         isGcall  <= next_isGcall;
         identPtr <= next_identPtr;
         sdaLow   <= next_sdaLow;
         cmd      <= next_cmd;
         timer    <= next_timer;
      end
   end

   // Open drain: drive low only
   assign bus.sdaSlaveOut = 1'b0;
   assign bus.sdaSlaveOe  = sdaLow;
   assign asleep          = (mode == MD_SLEEP);
   assign measuring       = (mode == MD_MEASURE) | (mode == MD_STOPPING);
   assign resetBusy       = (mode == MD_RESET);
   assign waking          = (mode == MD_WAKING);
endmodule

// ---- test/sfrsic_properties.sv ----
// Concurrent checks on the link and the sensor state
`timescale 1ns/10ps
module sfrsic_properties #(
   parameter int RESET_CYCLES = 400,
   parameter int WAKE_CYCLES  = 400
) (
   input logic sys_clk,
   input logic sys_rst,
   input logic scl,
   input logic sdaSlaveOe,
   input logic asleep,
   input logic measuring,
   input logic resetBusy,
   input logic waking
);
   int rCnt;
   int wCnt;
   // Counters give the length of the reset and wake windows in cycles
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rCnt <= 0;
         wCnt <= 0;
      end else begin
         rCnt <= resetBusy ? rCnt + 1 : 0;
         wCnt <= waking ? wCnt + 1 : 0;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   AST_SLEEP_IDLE: assert property (asleep |-> !measuring)
      else $error("asleep while measuring");
   AST_RESET_MUTE: assert property (resetBusy |-> !sdaSlaveOe)
      else $error("sensor drove the line during reset");
   AST_SLEEP_MUTE: assert property (asleep |-> !sdaSlaveOe)
      else $error("sensor drove the line while asleep");
   AST_WAKE_MUTE: assert property (waking |-> !sdaSlaveOe)
      else $error("sensor drove the line while waking");
   AST_RESET_LEN: assert property ($fell(resetBusy) |->
      rCnt inside {[RESET_CYCLES - 2 : RESET_CYCLES + 2]})
      else $error("reset window length wrong");
   AST_WAKE_LEN: assert property ($fell(waking) |->
      wCnt inside {[WAKE_CYCLES - 2 : WAKE_CYCLES + 2]})
      else $error("wake window length wrong");
   AST_WAKE_START: assert property ($fell(asleep) |-> waking)
      else $error("left sleep without waking");
   AST_WAKE_IDLE: assert property ($fell(waking) |->
      !asleep && !measuring && !resetBusy)
      else $error("wake did not end in idle");
   AST_SDA_TIMING: assert property ($changed(sdaSlaveOe) |-> !scl)
      else $error("sensor changed data while clock high");
   COV_RESET: cover property ($fell(resetBusy));
   COV_SLEEP: cover property ($rose(asleep));
   COV_WAKE: cover property ($fell(waking));
endmodule

// ---- test/tb_sensor_reset_sleep_id_crc.sv ----
// Bench: master end drives the sensor end through the shared link
`timescale 1ns/10ps
module tb_sensor_reset_sleep_id_crc;
   localparam int RC = 400;
   localparam int WC = 400;
   localparam logic [6:0] AD = 7'h2e;
   localparam logic [95:0] ID = {24'h3c3c3c, 8'h21, 64'hbeef001122334455}; // Arbitrary
   logic        sys_clk = 0;
   logic        sys_rst = 1;
   logic        clkEn = 1;
   logic        reqValid = 0;
   logic        reqRead = 0;
   logic [6:0]  reqAddr = 0;
   logic [1:0]  reqWrLen = 0;
   logic [15:0] reqWrData = 0;
   logic [4:0]  reqRdLen = 0;
   logic        reqReady, addrAcked, rdValid, done, crcOk;
   logic        asleep, measuring, resetBusy, waking;
   logic [7:0]  rdData;
   logic [7:0]  rd [18];
   int          fails = 0;
   int          checks = 0;
   int          t;
   always #50 sys_clk = ~sys_clk;
   sfrsic_bus_if sfrsic_bus_if_inst ();
   sfrsic_sensor #(.PRODUCT_BASE(ID[95:72]), .REVISION(ID[71:64]),
      .SERIAL_NUMBER(ID[63:0]), .RESET_CYCLES(RC), .WAKE_CYCLES(WC),
      .STOP_CYCLES(20)) sfrsic_sensor_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .clkEn(clkEn), .bus(sfrsic_bus_if_inst), .asleep(asleep), .measuring(measuring),
      .resetBusy(resetBusy), .waking(waking));
   sfrsic_master sfrsic_master_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .bus(sfrsic_bus_if_inst), .reqValid(reqValid), .reqReady(reqReady),
      .reqAddr(reqAddr), .reqRead(reqRead), .reqWrLen(reqWrLen), .reqWrData(reqWrData),
      .reqRdLen(reqRdLen), .addrAcked(addrAcked), .rdValid(rdValid), .rdData(rdData),
      .done(done), .crcOk(crcOk));
   sfrsic_properties #(.RESET_CYCLES(RC), .WAKE_CYCLES(WC)) props_inst (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .scl(sfrsic_bus_if_inst.scl),
      .sdaSlaveOe(sfrsic_bus_if_inst.sdaSlaveOe), .asleep(asleep),
      .measuring(measuring), .resetBusy(resetBusy), .waking(waking));
   function automatic logic [7:0] crc8(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--) c = (c[7] ^ w[i]) ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
      return c;
   endfunction
   task automatic conclude;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One whole transfer; commands take effect after their ack, then settle after the stop
   task automatic xfer(input logic [6:0] a, input logic r, input logic [1:0] wl,
                       input logic [15:0] wd, input logic [4:0] rl);
      int n;
      int k;
      n = 0;
      k = 0;
      @(negedge sys_clk);
      {reqAddr, reqRead, reqWrLen, reqWrData, reqRdLen} = {a, r, wl, wd, rl};
      reqValid = 1;
      while (reqReady !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 50) begin
         fails++;
         conclude();
      end
      @(negedge sys_clk);
      reqValid = 0;
      while (done !== 1'b1 && n < 3000) begin
         if (rdValid === 1'b1 && k < 18) rd[k++] = rdData;
         @(negedge sys_clk);
         n++;
      end
      if (n >= 3000) begin
         fails++;
         conclude();
      end
      repeat (8) @(negedge sys_clk);
   endtask
   task automatic poll(output int tries);
      tries = 0;
      do begin
         xfer(AD, 0, 0, 16'h0, 0);
         tries++;
      end while (addrAcked !== 1'b1 && tries < 20);
      chk(addrAcked, 1);
   endtask
   initial begin
      repeat (8) @(negedge sys_clk);
      sys_rst = 0;
      xfer(AD, 0, 2, 16'he102, 0);
      chk(addrAcked, 1);
      xfer(AD, 1, 0, 16'h0, 18);
      for (int k = 0; k < 6; k++) begin
         chk(rd[3*k], ID[95-16*k -: 8]);
         chk(rd[3*k+1], ID[87-16*k -: 8]);
         chk(rd[3*k+2], crc8(ID[95-16*k -: 16]));
      end
      chk(crcOk, 1);
      xfer(AD, 0, 2, 16'h3603, 0);
      xfer(AD, 0, 2, 16'h3677, 0);
      chk({asleep, measuring}, 2'b01);
      xfer(7'h00, 0, 1, 16'h0600, 0);
      chk(resetBusy, 1);
      poll(t);
      chk(t > 1, 1);
      chk(measuring, 0);
      xfer(AD, 0, 2, 16'h3603, 0);
      xfer(AD, 0, 2, 16'he102, 0);
      xfer(AD, 1, 0, 16'h0, 3);
      chk(rd[0], 8'hff);
      chk(rd[1], 8'hff);
      xfer(AD, 0, 2, 16'h3ff9, 0);
      for (t = 0; t < 40 && measuring !== 1'b0; t++) @(negedge sys_clk);
      chk(measuring, 0);
      xfer(AD, 0, 2, 16'h3677, 0);
      chk(asleep, 1);
      xfer(7'h00, 0, 1, 16'h0600, 0);
      chk({asleep, resetBusy}, 2'b10);
      xfer(7'h11, 0, 2, 16'he102, 0);
      xfer(AD, 1, 0, 16'h0, 3);
      chk(asleep, 1);
      xfer(AD, 0, 0, 16'h0, 0);
      chk({addrAcked, waking}, 2'b01);
      poll(t);
      chk(t > 1, 1);
      chk({asleep, waking}, 2'b00);
      conclude();
   end
endmodule
